/* indicator_pkg.sv */
// constants and types for the fieldbus status indicator block
package indicator_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned STATION_W = 7;
    localparam int unsigned BAUD_W = 3;
    // refresh timeout and flicker half period, in ms as chosen
    localparam int unsigned REFRESH_TIMEOUT_MS = 100;
    localparam int unsigned FLICKER_HALF_MS = 100;
    localparam int unsigned REFRESH_TIMEOUT_CYC =
        REFRESH_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned FLICKER_HALF_CYC =
        FLICKER_HALF_MS * (CLK_HZ / 1000);
    localparam logic [STATION_W-1:0] STATION_RST = 7'h01;
    localparam logic [BAUD_W-1:0] BAUD_RST = 3'h0;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
    localparam int unsigned NUM_EVT = 4;
    // event bit positions
    localparam int unsigned EVT_REFRESH = 0;
    localparam int unsigned EVT_TIMEOUT = 1;
    localparam int unsigned EVT_COMM_ERR = 2;
    localparam int unsigned EVT_SET_CHG = 3;
    typedef enum logic [1:0] {
        AX_IDLE = 2'b00,
        AX_WRESP = 2'b01,
        AX_RRESP = 2'b10
    } axi_state_t;
endpackage

/* fieldbus_status_indicators.sv */
// fieldbus option status indicators with axi4-lite register slave
`timescale 1ns/1ps
module fieldbus_status_indicators
    import indicator_pkg::*;
#(
    parameter int unsigned REFRESH_CYC = REFRESH_TIMEOUT_CYC,
    parameter int unsigned FLICKER_CYC = FLICKER_HALF_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // inverter reset input, pin
    input wire logic inverter_reset_input,
    // protocol engine events, same clock
    input wire logic refresh_ok,
    input wire logic own_comm_error,
    input wire logic tx_busy,
    input wire logic master_v1_only,
    // pins
    input wire logic rx_carrier,
    input wire logic [1:0] switch_setting,
    // settings to protocol engine
    output logic [indicator_pkg::STATION_W-1:0] station_number,
    output logic [indicator_pkg::BAUD_W-1:0] baud_select,
    output logic ver2_mode,
    // indicators
    output logic link_refresh_led,
    output logic link_fault_led,
    output logic power_ok_led,
    output logic transmit_activity_indicator,
    output logic receive_led,
    output logic irq,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import indicator_pkg::*;

    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // three-stage pin synchronisers, change counted when 2nd and 3rd agree
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
    logic [3:0] pin_raw;
    assign pin_raw = {switch_setting, rx_carrier, inverter_reset_input};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_q[gi] <= 1'b0;
                end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate
    logic inv_reset, carrier;
    logic [1:0] sw;
    assign inv_reset = pin_q[0];
    assign carrier = pin_q[1];
    assign sw = pin_q[3:2];
    // software-set parameters
    logic [STATION_W-1:0] station_q;
    logic [BAUD_W-1:0] baud_q;
    logic ver2_q;
    logic param_wr;
    logic [STATION_W-1:0] new_station;
    logic [BAUD_W-1:0] new_baud;

    // switch capture after reset, then change detection
    logic sw_valid_q;
    logic [1:0] sw_ref_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_valid_q <= 1'b0;
            sw_ref_q <= 2'h0;
        end else if (!sw_valid_q) begin
            sw_valid_q <= 1'b1;
            sw_ref_q <= sw;
        end
    end
    logic sw_changed;
    assign sw_changed = sw_valid_q && (sw != sw_ref_q);
    logic prm_changed;
    assign prm_changed = param_wr &&
        ((new_station != station_q) || (new_baud != baud_q));

    // latched flicker request, cleared only by reset or inverter reset
    logic set_flicker_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_flicker_q <= 1'b0;
        end else if (sw_changed || prm_changed) begin
            set_flicker_q <= 1'b1;
        end else if (inv_reset) begin
            set_flicker_q <= 1'b0;
        end
    end
    // refresh timeout
    logic [31:0] idle_cnt_q;
    logic link_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_cnt_q <= 32'h0;
            link_q <= 1'b0;
        end else if (refresh_ok) begin
            idle_cnt_q <= 32'h0;
            link_q <= 1'b1;
        end else if (link_q) begin
            if (idle_cnt_q >= REFRESH_CYC - 1) begin
                link_q <= 1'b0;
                idle_cnt_q <= 32'h0;
            end else begin
                idle_cnt_q <= idle_cnt_q + 32'h1;
            end
        end
    end
    // symmetric flicker source
    logic [31:0] flk_cnt_q;
    logic flk_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flk_cnt_q <= 32'h0;
            flk_q <= 1'b0;
        end else if (flk_cnt_q >= FLICKER_CYC - 1) begin
            flk_cnt_q <= 32'h0;
            flk_q <= ~flk_q;
        end else begin
            flk_cnt_q <= flk_cnt_q + 32'h1;
        end
    end
    // indicator outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_refresh_led <= 1'b0;
            link_fault_led <= 1'b0;
            power_ok_led <= 1'b0;
            transmit_activity_indicator <= 1'b0;
            receive_led <= 1'b0;
        end else begin
            link_refresh_led <= link_q;
            if (set_flicker_q) begin
                link_fault_led <= flk_q;
            end else begin
                link_fault_led <= own_comm_error;
            end
            if (ver2_q && master_v1_only) begin
                power_ok_led <= flk_q;
            end else begin
                power_ok_led <= 1'b1;
            end
            transmit_activity_indicator <= tx_busy;
            receive_led <= carrier;
        end
    end

    // settings drive the protocol engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            station_number <= STATION_RST;
            baud_select <= BAUD_RST;
            ver2_mode <= 1'b0;
        end else begin
            station_number <= station_q;
            baud_select <= baud_q;
            ver2_mode <= ver2_q;
        end
    end

    // interrupt events
    logic link_d1_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_d1_q <= 1'b0;
        end else begin
            link_d1_q <= link_q;
        end
    end
    logic [NUM_EVT-1:0] evt;
    always_comb begin
        evt = '0;
        evt[EVT_REFRESH] = refresh_ok;
        evt[EVT_TIMEOUT] = link_d1_q && !link_q;
        evt[EVT_COMM_ERR] = own_comm_error;
        evt[EVT_SET_CHG] = (sw_changed || prm_changed) && !set_flicker_q;
    end

    // axi4-lite slave: one write and one read at a time
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    OFS_CTRL, OFS_IRQ_EN, OFS_IRQ_CLR, OFS_STATUS,
                    OFS_IRQ_STAT: begin
                        s_axi_bresp <= RESP_OK;
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register: [6:0] station, [10:8] baud, [16] ver2
    assign param_wr = wr_go && (aw_addr_q == OFS_CTRL);
    always_comb begin
        new_station = station_q;
        new_baud = baud_q;
        if (w_strb_q[0]) begin
            new_station = w_data_q[STATION_W-1:0];
        end
        if (w_strb_q[1]) begin
            new_baud = w_data_q[8 +: BAUD_W];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            station_q <= STATION_RST;
            baud_q <= BAUD_RST;
            ver2_q <= 1'b0;
        end else if (param_wr) begin
            station_q <= new_station;
            baud_q <= new_baud;
            if (w_strb_q[2]) begin
                ver2_q <= w_data_q[16];
            end
        end
    end

    // sticky status, enable, write-one-to-clear; set wins
    logic [NUM_EVT-1:0] irq_stat_q, irq_en_q, irq_clr;
    assign irq_clr = (wr_go && aw_addr_q == OFS_IRQ_CLR && w_strb_q[0]) ?
        w_data_q[NUM_EVT-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | evt;
            if (wr_go && aw_addr_q == OFS_IRQ_EN && w_strb_q[0]) begin
                irq_en_q <= w_data_q[NUM_EVT-1:0];
            end
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // read channel
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFS_CTRL: begin
                rd_word[STATION_W-1:0] = station_q;
                rd_word[8 +: BAUD_W] = baud_q;
                rd_word[16] = ver2_q;
            end
            OFS_STATUS: begin
                rd_word[0] = link_refresh_led;
                rd_word[1] = link_fault_led;
                rd_word[2] = power_ok_led;
                rd_word[3] = transmit_activity_indicator;
                rd_word[4] = receive_led;
                rd_word[5] = set_flicker_q;
                rd_word[9:8] = sw;
            end
            OFS_IRQ_STAT: rd_word[NUM_EVT-1:0] = irq_stat_q;
            OFS_IRQ_EN: rd_word[NUM_EVT-1:0] = irq_en_q;
            OFS_IRQ_CLR: rd_word = 32'h0;
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* fsi_properties.sv */
// checker for the status indicator block ports
`timescale 1ns/1ps
module fsi_checker #(
    parameter int unsigned REFRESH_CYC = 20,
    parameter int unsigned FLICKER_CYC = 8
) (
    // clock, reset, events
    input logic aclk,
    input logic aresetn,
    input logic refresh_ok,
    input logic tx_busy,
    input logic master_v1_only,
    input logic rx_carrier,
    // settings and lamps
    input logic [indicator_pkg::STATION_W-1:0] station_number,
    input logic ver2_mode,
    input logic link_refresh_led,
    input logic power_ok_led,
    input logic transmit_activity_indicator,
    input logic receive_led,
    // register bus
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready
);
    import indicator_pkg::*;
    int unsigned lcnt_q;
    int unsigned pcnt_q;
    logic [1:0] pflk_q;
    wire pf = ver2_mode && master_v1_only;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // cycles since the last refresh, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcnt_q <= REFRESH_CYC + 4;
        end else if (refresh_ok) begin
            lcnt_q <= 0;
        end else if (lcnt_q < REFRESH_CYC + 4) begin
            lcnt_q <= lcnt_q + 1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || $changed(power_ok_led)) begin
            pcnt_q <= 0;
        end else begin
            pcnt_q <= pcnt_q + 1;
        end
    end
    // two toggles seen under flicker before timing them
    always_ff @(posedge aclk) begin
        if (!aresetn || !pf) begin
            pflk_q <= 2'd0;
        end else if ($changed(power_ok_led) && $past(pf) && !pflk_q[1]) begin
            pflk_q <= pflk_q + 2'd1;
        end
    end
    link_on_a: assert property (
        refresh_ok |-> ##2 link_refresh_led)
        else $error("link lamp not lit after refresh");
    link_off_a: assert property (
        lcnt_q >= REFRESH_CYC + 3 |-> !link_refresh_led)
        else $error("link lamp lit past timeout");
    power_on_a: assert property (!pf [*4] |-> power_ok_led)
        else $error("power lamp not steady");
    power_flicker_a: assert property (
        $changed(power_ok_led) && pflk_q == 2'd2 |-> pcnt_q == FLICKER_CYC - 1)
        else $error("power lamp flicker period wrong");
    rx_lamp_a: assert property (
        $stable(rx_carrier) [*8] |-> receive_led == rx_carrier)
        else $error("receive lamp not following carrier");
    tx_off_a: assert property (
        !tx_busy [*2] |-> !transmit_activity_indicator)
        else $error("transmit lamp lit while idle");
    reset_val_a: assert property (disable iff (1'b0)
        !aresetn |=> station_number == STATION_RST && !power_ok_led)
        else $error("reset values wrong");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (refresh_ok ##2 link_refresh_led);
    cover property ($changed(power_ok_led) && pflk_q == 2'd2);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind fieldbus_status_indicators fsi_checker #(
    .REFRESH_CYC(REFRESH_CYC),
    .FLICKER_CYC(FLICKER_CYC)
) chk_u (.*);

/* master_model.sv */
// network master model: frames with carrier and refresh result
`timescale 1ns/1ps
module master_model (
    // bench commands
    input wire logic aclk,
    input wire logic frame_go,
    input wire logic frame_bad,
    input wire logic v1_only,
    // towards the option
    output logic refresh_ok,
    output logic rx_carrier,
    output logic master_v1_only
);
    // model only: power-up value given here, so a plain process drives it
    logic [3:0] cnt_q = 4'h0;
    always @(posedge aclk) begin
        if (frame_go) begin
            cnt_q <= 4'h8;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // carrier only within a frame, refresh at its end
    assign rx_carrier = cnt_q != 4'h0;
    assign refresh_ok = cnt_q == 4'h1 && !frame_bad;
    assign master_v1_only = v1_only;
endmodule

/* tb_top.sv */
// self-checking bench for the status indicator block
`timescale 1ns/1ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module tb_top;
    import indicator_pkg::*;
    localparam int unsigned RC = 20;
    localparam int unsigned FC = 8;
    logic aclk, aresetn, inverter_reset_input, own_comm_error, tx_busy;
    logic refresh_ok, rx_carrier, master_v1_only, frame_go, frame_bad;
    logic v1_only, ver2_mode, link_refresh_led, link_fault_led, irq;
    logic power_ok_led, transmit_activity_indicator, receive_led;
    logic [1:0] switch_setting, s_axi_bresp, s_axi_rresp, rsp;
    logic [STATION_W-1:0] station_number;
    logic [BAUD_W-1:0] baud_select;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int failures = 0;
    int total_checks = 0;
    int nf, np;
    fieldbus_status_indicators #(
        .REFRESH_CYC(RC),
        .FLICKER_CYC(FC)
    ) dut_u (.*);
    master_model far_u (.*);
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic guard(input int n);
        if (n >= 50) begin
            failures++;
            end_sim();
        end
    endtask
    // ready is raised late so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        rsp = s_axi_bresp;
        guard(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        guard(n);
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        cyc(12);
        aresetn <= 1'b1;
    endtask
    // lamp on-time of fault and power over n cycles
    task automatic count(input int n);
        nf = 0;
        np = 0;
        repeat (n) begin
            @(posedge aclk);
            nf += (link_fault_led === 1'b1);
            np += (power_ok_led === 1'b1);
        end
    endtask
    task automatic frame(input logic bad);
        frame_bad <= bad;
        frame_go <= 1'b1;
        cyc(1);
        frame_go <= 1'b0;
    endtask
    task automatic t_reset();
        `CHK(station_number, STATION_RST)
        `CHK(baud_select, BAUD_RST)
        // power lamp leaves its reset value one edge after release
        cyc(2);
        count(2 * FC);
        `CHK(np, 2 * FC)
        rd(OFS_CTRL);
        `CHK(rd_d, 32'h0000_0001)
        rd(8'h14);
        `CHK({rsp, rd_d}, 34'h2_0000_0000)
        $display("reset test done");
    endtask
    task automatic t_link();
        frame(1'b0);
        cyc(7);
        `CHK(receive_led, 1'b1)
        cyc(6);
        `CHK(link_refresh_led, 1'b1)
        cyc(6);
        `CHK(receive_led, 1'b0)
        cyc(RC);
        `CHK(link_refresh_led, 1'b0)
        frame(1'b1);
        cyc(14);
        `CHK(link_refresh_led, 1'b0)
        $display("link test done");
    endtask
    task automatic t_fault();
        own_comm_error <= 1'b1;
        tx_busy <= 1'b1;
        cyc(3);
        `CHK(transmit_activity_indicator, 1'b1)
        tx_busy <= 1'b0;
        count(2 * FC);
        `CHK(nf, 2 * FC)
        `CHK(transmit_activity_indicator, 1'b0)
        own_comm_error <= 1'b0;
        cyc(3);
        `CHK(link_fault_led, 1'b0)
        $display("fault test done");
    endtask
    task automatic t_param();
        wr(OFS_CTRL, 32'h0000_052a);
        own_comm_error <= 1'b1;
        cyc(2);
        `CHK(station_number, 7'h2a)
        `CHK(baud_select, 3'h5)
        count(2 * FC);
        `CHK(nf, FC)
        inverter_reset_input <= 1'b1;
        cyc(6);
        inverter_reset_input <= 1'b0;
        cyc(6);
        count(2 * FC);
        `CHK(nf, 2 * FC)
        own_comm_error <= 1'b0;
        $display("parameter test done");
    endtask
    task automatic t_switch();
        switch_setting <= 2'b01;
        cyc(8);
        count(2 * FC);
        `CHK(nf, FC)
        switch_setting <= 2'b00;
        do_reset();
        cyc(8);
        count(2 * FC);
        `CHK(nf, 0)
        $display("switch test done");
    endtask
    task automatic t_power();
        wr(OFS_CTRL, 32'h0001_0001);
        v1_only <= 1'b1;
        cyc(4);
        `CHK(ver2_mode, 1'b1)
        count(2 * FC);
        `CHK(np, FC)
        `CHK(nf, 0)
        v1_only <= 1'b0;
        cyc(3);
        count(2 * FC);
        `CHK(np, 2 * FC)
        $display("power test done");
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_CLR, 32'h0000_000f);
        wr(OFS_IRQ_EN, 32'h0000_0004);
        cyc(2);
        `CHK(irq, 1'b0)
        own_comm_error <= 1'b1;
        cyc(1);
        own_comm_error <= 1'b0;
        cyc(3);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_EN, 32'h0000_0000);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_CLR, 32'h0000_0004);
        rd(OFS_IRQ_STAT);
        `CHK(rd_d[EVT_COMM_ERR], 1'b0)
        wr(8'h40, 32'h0000_0001);
        `CHK(rsp, 2'b10)
        $display("interrupt test done");
    endtask
    initial begin
        {aresetn, inverter_reset_input, own_comm_error, tx_busy} = 4'h0;
        {frame_go, frame_bad, v1_only, switch_setting} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        do_reset();
        t_reset();
        t_link();
        t_fault();
        t_param();
        t_switch();
        t_power();
        t_irq();
        end_sim();
    end
endmodule
